// *** rtl/adcc_pkg.sv ***
// adcc_pkg: constants shared by the converter control block and its helper.
// assumes a 20 MHz system clock; no other dependency.
package adcc_pkg;
    // ------------------------------------------------------------
    // widths and codes
    // ------------------------------------------------------------
    localparam int          WORD_W      = 12;
    localparam int          CNT_W       = 16;
    localparam int          PER_W       = 8;
    localparam logic [11:0] CODE_POS_FS = 12'hfff;
    localparam logic [11:0] CODE_NEG_FS = 12'h000;
    localparam int          MSB         = 11;
    // strap levels: ground, third, two thirds, full supply
    localparam logic [1:0]  MODE_GND    = 2'h0;
    localparam logic [1:0]  MODE_THIRD  = 2'h1;
    localparam logic [1:0]  MODE_2THIRD = 2'h2;
    localparam logic [1:0]  MODE_VDD    = 2'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 50;
    localparam int MIN_RATE_PER_NS  = 1000;
    localparam int SLOW_CYCLES      = MIN_RATE_PER_NS / CLK_PERIOD_NS;
    localparam int LOCK_EDGES       = 100;
    localparam int NAP_EDGES        = 100;
    localparam int SLEEP_REC_MS     = 2;
    localparam int SLEEP_REC_CYCLES = SLEEP_REC_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PIPE_LAT         = 5;

    // ------------------------------------------------------------
    // register map (byte offsets) and fields
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL     = 5'h00;
    localparam logic [4:0] OFS_STATUS   = 5'h04;
    localparam logic [4:0] OFS_IRQ_STAT = 5'h08;
    localparam logic [4:0] OFS_IRQ_CLR  = 5'h0c;
    localparam logic [4:0] OFS_IRQ_EN   = 5'h10;
    localparam logic [4:0] OFS_LAST     = 5'h14;
    localparam int         CTRL_OVR     = 0;
    localparam int         CTRL_MODE_LO = 1;
    localparam int         ST_TWOS      = 0;
    localparam int         ST_DCS       = 1;
    localparam int         ST_PW_LO     = 2;
    localparam int         ST_LOCK      = 5;
    localparam int         ST_VALID     = 6;
    localparam int         EV_W         = 4;
    localparam int         EV_OVF       = 0;
    localparam int         EV_STOP      = 1;
    localparam int         EV_VALID     = 2;
    localparam int         EV_PDOWN     = 3;

    typedef enum logic [2:0] {
        PW_RUN   = 3'b001,
        PW_NAP   = 3'b010,
        PW_SLEEP = 3'b100
    } adcc_pw_t;
endpackage : adcc_pkg

// *** rtl/adcc_settle_cnt.sv ***
// adcc_settle_cnt: counts steps after a restart and flags when a target is met.
// assumes steps are one-cycle pulses in the sys_clk domain.
`timescale 1ns/1ps
module adcc_settle_cnt #(
    parameter int W = 16
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire logic         restart,
    input  wire logic         step,
    input  wire logic [W-1:0] target,
    output logic              done
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (restart) begin
            cnt_next = '0;
        end else if (step && !done) begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (clk_en) begin
            cnt_reg <= cnt_next;
        end
    end

    // saturates at target so a long run never wraps back to invalid
    assign done = (cnt_reg >= target);
endmodule : adcc_settle_cnt

// *** rtl/adcc_ctrl.sv ***
// adcc_ctrl: sampling edge control, output coding, power modes and register slave
// assumes sample clock edges arrive as sys_clk-synchronous pulses, core code
// is raw offset binary with over/under flags, and an avalon-mm master.
`timescale 1ns/1ps
module adcc_ctrl #(
    parameter int SLEEP_CYC = adcc_pkg::SLEEP_REC_CYCLES,
    parameter int LAT       = adcc_pkg::PIPE_LAT
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        samp_clk_rise,
    input  wire logic        samp_clk_fall,
    input  wire logic [11:0] core_code,
    input  wire logic        core_over,
    input  wire logic        core_under,
    input  wire logic [1:0]  mode_level,
    input  wire logic        power_down_select,
    input  wire logic        out_ctrl_n,
    output logic      [11:0] sample_word,
    output logic             sample_word_oe,
    output logic             overflow_flag,
    output logic             overflow_flag_oe,
    output logic             data_valid,
    output logic             irq,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    // ------------------------------------------------------------
    // mode selection
    // ------------------------------------------------------------
    logic [2:0] ctrl_reg, ctrl_next;
    logic [1:0] mode_eff;
    logic       fmt_twos, dcs_on;

    always_comb begin
        mode_eff = ctrl_reg[adcc_pkg::CTRL_OVR] ? ctrl_reg[2:1] : mode_level;
        unique case (mode_eff)
            adcc_pkg::MODE_GND:    begin fmt_twos = 1'b0; dcs_on = 1'b0; end
            adcc_pkg::MODE_THIRD:  begin fmt_twos = 1'b0; dcs_on = 1'b1; end
            adcc_pkg::MODE_2THIRD: begin fmt_twos = 1'b1; dcs_on = 1'b1; end
            adcc_pkg::MODE_VDD:    begin fmt_twos = 1'b1; dcs_on = 1'b0; end
        endcase
    end

    // ------------------------------------------------------------
    // sampling window and stabiliser
    // ------------------------------------------------------------
    logic [adcc_pkg::PER_W-1:0] per_cnt_reg, per_cnt_next, meas_reg, meas_next;
    logic                       win_reg, win_next, held_of_reg, held_of_next;
    logic [11:0]                held_word_reg, held_word_next;
    logic                       int_fall, fall_evt, cap, stop_evt, at_slow;

    always_comb begin
        at_slow   = (per_cnt_reg == adcc_pkg::PER_W'(adcc_pkg::SLOW_CYCLES));
        stop_evt  = !samp_clk_rise
                  && (per_cnt_reg == adcc_pkg::PER_W'(adcc_pkg::SLOW_CYCLES - 1));
        // internal fall half a measured period after each rise
        int_fall  = dcs_on && !samp_clk_rise && (meas_reg[adcc_pkg::PER_W-1:1] != '0)
                  && (per_cnt_reg == (meas_reg >> 1));
        fall_evt  = dcs_on ? int_fall : samp_clk_fall;
        cap       = samp_clk_rise && win_reg;
        per_cnt_next = samp_clk_rise ? '0 : (at_slow ? per_cnt_reg : per_cnt_reg + 1'b1);
        meas_next    = samp_clk_rise ? per_cnt_reg + 1'b1 : meas_reg;
        win_next     = samp_clk_rise ? 1'b0 : (fall_evt ? 1'b1 : win_reg);
        held_word_next = held_word_reg;
        held_of_next   = held_of_reg;
        if (cap) begin
            held_of_next = core_over || core_under;
            held_word_next = core_over  ? adcc_pkg::CODE_POS_FS
                           : core_under ? adcc_pkg::CODE_NEG_FS : core_code;
            held_word_next[adcc_pkg::MSB] = held_word_next[adcc_pkg::MSB] ^ fmt_twos;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            per_cnt_reg   <= '0;
            meas_reg      <= '0;
            win_reg       <= 1'b0;
            held_word_reg <= 12'h000;
            held_of_reg   <= 1'b0;
        end else if (clk_en) begin
            per_cnt_reg   <= per_cnt_next;
            meas_reg      <= meas_next;
            win_reg       <= win_next;
            held_word_reg <= held_word_next;
            held_of_reg   <= held_of_next;
        end
    end

    // ------------------------------------------------------------
    // power modes and recovery
    // ------------------------------------------------------------
    adcc_pkg::adcc_pw_t pw_reg, pw_next;
    logic from_sleep_reg, from_sleep_next;
    logic lock_done, nap_done, sleep_done, run;

    always_comb begin
        if (!power_down_select) begin
            pw_next = adcc_pkg::PW_RUN;
        end else if (out_ctrl_n) begin
            pw_next = adcc_pkg::PW_SLEEP;
        end else begin
            pw_next = adcc_pkg::PW_NAP;
        end
        run = (pw_reg == adcc_pkg::PW_RUN);
        from_sleep_next = run ? from_sleep_reg : (pw_reg == adcc_pkg::PW_SLEEP);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pw_reg         <= adcc_pkg::PW_RUN;
            from_sleep_reg <= 1'b0;
        end else if (clk_en) begin
            pw_reg         <= pw_next;
            from_sleep_reg <= from_sleep_next;
        end
    end
    // loop relocks after a stall slower than the minimum rate
    adcc_settle_cnt #(.W(adcc_pkg::CNT_W)) u_lock (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .restart (stop_evt || !run),
        .step    (samp_clk_rise),
        .target  (adcc_pkg::CNT_W'(adcc_pkg::LOCK_EDGES)),
        .done    (lock_done)
    );
    // nap recovery counts sample edges
    adcc_settle_cnt #(.W(adcc_pkg::CNT_W)) u_nap (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .restart (!run),
        .step    (samp_clk_rise),
        .target  (adcc_pkg::CNT_W'(adcc_pkg::NAP_EDGES)),
        .done    (nap_done)
    );
    // sleep recovery counts system cycles: reference recharge is a time
    adcc_settle_cnt #(.W(adcc_pkg::CNT_W)) u_sleep (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .restart (!run),
        .step    (1'b1),
        .target  (adcc_pkg::CNT_W'(SLEEP_CYC)),
        .done    (sleep_done)
    );
    // ------------------------------------------------------------
    // output pipeline
    // ------------------------------------------------------------
    logic [11:0] pipe_w_reg [LAT];
    logic [11:0] pipe_w_next [LAT];
    logic [LAT-1:0] pipe_of_reg, pipe_of_next;
    logic [11:0] word_reg, word_next;
    logic        of_reg, of_next, oe_reg, oe_next, dv_reg, dv_next;

    always_comb begin
        pipe_w_next  = pipe_w_reg;
        pipe_of_next = pipe_of_reg;
        word_next    = word_reg;
        of_next      = of_reg;
        if (samp_clk_rise) begin
            pipe_w_next[0]  = held_word_reg;
            pipe_of_next[0] = held_of_reg;
            for (int i = 1; i < LAT; i++) begin
                pipe_w_next[i]  = pipe_w_reg[i-1];
                pipe_of_next[i] = pipe_of_reg[i-1];
            end
            word_next = pipe_w_reg[LAT-1];
            of_next   = pipe_of_reg[LAT-1];
        end
        oe_next = run && !out_ctrl_n;
        dv_next = run && nap_done && (sleep_done || !from_sleep_reg)
                && (lock_done || !dcs_on);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pipe_w_reg  <= '{default: 12'h000};
            pipe_of_reg <= '0;
            word_reg    <= 12'h000;
            of_reg      <= 1'b0;
            oe_reg      <= 1'b0;
            dv_reg      <= 1'b0;
        end else if (clk_en) begin
            pipe_w_reg  <= pipe_w_next;
            pipe_of_reg <= pipe_of_next;
            word_reg    <= word_next;
            of_reg      <= of_next;
            oe_reg      <= oe_next;
            dv_reg      <= dv_next;
        end
    end

    // ------------------------------------------------------------
    // register slave and interrupts
    // ------------------------------------------------------------
    logic [adcc_pkg::EV_W-1:0] ist_reg, ist_next, ien_reg, ien_next, ev, clr;
    logic [31:0] rd_reg, rd_next;
    logic        wait_reg, wait_next, irq_reg, irq_next, req, wr_ack;

    always_comb begin
        req    = avs_read || avs_write;
        // one wait state: answer comes the cycle after a request is seen
        wait_next = !(req && wait_reg);
        wr_ack = avs_write && !wait_reg;
        ctrl_next = ctrl_reg;
        ien_next  = ien_reg;
        clr       = '0;
        if (wr_ack && avs_byteenable[0]) begin
            unique case (avs_address)
                adcc_pkg::OFS_CTRL:    ctrl_next = avs_writedata[2:0];
                adcc_pkg::OFS_IRQ_CLR: clr = avs_writedata[adcc_pkg::EV_W-1:0];
                adcc_pkg::OFS_IRQ_EN:  ien_next = avs_writedata[adcc_pkg::EV_W-1:0];
                default:               ctrl_next = ctrl_reg;
            endcase
        end
        ev = '0;
        ev[adcc_pkg::EV_OVF]   = cap && (core_over || core_under);
        ev[adcc_pkg::EV_STOP]  = stop_evt;
        ev[adcc_pkg::EV_VALID] = dv_next && !dv_reg;
        ev[adcc_pkg::EV_PDOWN] = run && (pw_next != adcc_pkg::PW_RUN);
        ist_next = (ist_reg & ~clr) | ev;      // a new event beats a same-cycle clear
        irq_next = |(ist_reg & ien_reg);
        rd_next  = rd_reg;
        if (avs_read && wait_reg) begin
            rd_next = 32'h0000_0000;
            unique case (avs_address)
                adcc_pkg::OFS_CTRL:     rd_next[2:0] = ctrl_reg;
                adcc_pkg::OFS_STATUS: begin
                    rd_next[adcc_pkg::ST_TWOS]  = fmt_twos;
                    rd_next[adcc_pkg::ST_DCS]   = dcs_on;
                    rd_next[adcc_pkg::ST_PW_LO +: 3] = pw_reg;
                    rd_next[adcc_pkg::ST_LOCK]  = lock_done;
                    rd_next[adcc_pkg::ST_VALID] = dv_reg;
                end
                adcc_pkg::OFS_IRQ_STAT: rd_next[adcc_pkg::EV_W-1:0] = ist_reg;
                adcc_pkg::OFS_IRQ_EN:   rd_next[adcc_pkg::EV_W-1:0] = ien_reg;
                adcc_pkg::OFS_LAST:     rd_next[12:0] = {of_reg, word_reg};
                default:                rd_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_reg <= 3'h0;
            ien_reg  <= '0;
            ist_reg  <= '0;
            rd_reg   <= 32'h0000_0000;
            wait_reg <= 1'b1;
            irq_reg  <= 1'b0;
        end else if (clk_en) begin
            ctrl_reg <= ctrl_next;
            ien_reg  <= ien_next;
            ist_reg  <= ist_next;
            rd_reg   <= rd_next;
            wait_reg <= wait_next;
            irq_reg  <= irq_next;
        end
    end

    assign sample_word      = word_reg;
    assign overflow_flag    = of_reg;
    assign sample_word_oe   = oe_reg;
    assign overflow_flag_oe = oe_reg;
    assign data_valid       = dv_reg;
    assign irq              = irq_reg;
    assign avs_readdata     = rd_reg;
    assign avs_waitrequest  = wait_reg;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_pd_held;
        clk_en && power_down_select ##1 clk_en && power_down_select;
    endsequence
    sequence s_cap_plain;
        clk_en && cap && !core_over && !core_under;
    endsequence
    a_ext_fall_ignored: assert property (clk_en && dcs_on && !win_reg && samp_clk_fall
        && !int_fall && !samp_clk_rise |=> !win_reg) else $error("external fall opened window");
    a_half_period: assert property ($rose(win_reg) && dcs_on && $past(dcs_on)
        |-> per_cnt_reg == (meas_reg >> 1) + 1'b1) else $error("fall not at half period");
    a_relock_gate: assert property (clk_en && dcs_on && !lock_done |=> !dv_reg)
        else $error("valid before stabiliser lock");
    a_offset_binary: assert property (s_cap_plain and !fmt_twos
        |=> held_word_reg == $past(core_code)) else $error("offset binary code wrong");
    a_twos_msb: assert property (s_cap_plain and fmt_twos
        |=> held_word_reg == {~$past(core_code[11]), $past(core_code[10:0])})
        else $error("twos complement code wrong");
    a_over_sat: assert property (clk_en && cap && core_over |=> held_of_reg
        && held_word_reg[10:0] == adcc_pkg::CODE_POS_FS[10:0]) else $error("no saturation");
    a_strap_map: assert property (mode_eff == adcc_pkg::MODE_2THIRD |-> fmt_twos && dcs_on)
        else $error("strap mapping wrong");
    a_oe_float: assert property (clk_en && out_ctrl_n |=> !sample_word_oe && !overflow_flag_oe)
        else $error("outputs driven while disabled");
    a_normal_run: assert property (clk_en && !power_down_select |=> pw_reg == adcc_pkg::PW_RUN)
        else $error("not converting with power down low");
    a_sleep_hold: assert property (clk_en && run && from_sleep_reg && !sleep_done |=> !dv_reg)
        else $error("valid during sleep recovery");
    a_nap_enter: assert property (clk_en && power_down_select && !out_ctrl_n
        |=> pw_reg == adcc_pkg::PW_NAP ##1 !dv_reg) else $error("nap not entered");
    a_pd_float: assert property (s_pd_held |=> !sample_word_oe && !overflow_flag_oe)
        else $error("outputs driven in power down");
    a_window_open: assert property (clk_en && !dcs_on && samp_clk_fall && !samp_clk_rise
        |=> win_reg) else $error("window did not open on fall");
    a_word_steady: assert property (!(clk_en && samp_clk_rise) |=> $stable(word_reg))
        else $error("word changed off sample edge");
endmodule : adcc_ctrl

// *** verif/adcc_cap_model.sv ***
// adcc_cap_model: far-side capture logic and sample clock source
// assumes sys_clk at 20 MHz; run low stops the sample clock
`timescale 1ns/1ps
module adcc_cap_model #(
    parameter int PER = 10
) (
    input  wire logic        sys_clk,
    input  wire logic        run,
    output logic             samp_clk_rise,
    output logic             samp_clk_fall,
    input  wire logic [11:0] sample_word,
    input  wire logic        sample_word_oe,
    input  wire logic        overflow_flag,
    output logic      [12:0] cap_reg
);
    int cnt = 0;
    initial begin
        samp_clk_rise = 1'b0;
        samp_clk_fall = 1'b0;
        cap_reg = 13'h0000;
    end
    // 2 msps, even duty, 250 ns phases: inside every grade and above the droop floor
    always @(posedge sys_clk) begin
        cnt           <= run ? (cnt + 1) % PER : 0;
        samp_clk_rise <= run && cnt == PER - 1;
        samp_clk_fall <= run && cnt == PER / 2 - 1;
    end
    // one fixed edge; a floated bus is never taken
    always @(posedge sys_clk) begin
        if (samp_clk_rise && sample_word_oe) begin
            cap_reg <= {overflow_flag, sample_word};
        end
    end
endmodule : adcc_cap_model

// *** verif/adcc_ctrl_tb.sv ***
// adcc_ctrl_tb: self-checking bench for the converter control block
// assumes the capture model as clock source and a queue model of the pipe
`timescale 1ns/1ps
module adcc_ctrl_tb;
    localparam int LAT = 2;
    logic sys_clk = 1'b0, rst_n = 1'b0, run = 1'b1, cmp = 1'b0;
    logic [11:0] core_code = 12'h800, sample_word;
    logic core_over = 1'b0, core_under = 1'b0, pds = 1'b0, oc_n = 1'b0;
    logic [1:0] mode_level = 2'h0;
    logic rise, fall, sample_word_oe, overflow_flag, overflow_flag_oe, data_valid, irq;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    int num_errors = 0, n_checks = 0, r;
    logic [12:0] q[$], cap, prev;
    bit          pv = 1'b0;

    adcc_ctrl #(.SLEEP_CYC(2000), .LAT(LAT)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .clk_en(1'b1), .samp_clk_rise(rise), .samp_clk_fall(fall), .core_code(core_code),
        .core_over(core_over), .core_under(core_under), .mode_level(mode_level),
        .power_down_select(pds), .out_ctrl_n(oc_n), .sample_word(sample_word),
        .sample_word_oe(sample_word_oe), .overflow_flag(overflow_flag),
        .overflow_flag_oe(overflow_flag_oe), .data_valid(data_valid), .irq(irq),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    adcc_cap_model u_cap (.sys_clk(sys_clk), .run(run), .samp_clk_rise(rise),
        .samp_clk_fall(fall), .sample_word(sample_word), .sample_word_oe(sample_word_oe),
        .overflow_flag(overflow_flag), .cap_reg(cap));

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test

    // ----------------------------------------------------------
    // bus master and waits
    // ----------------------------------------------------------
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // no local limit: a slave that never answers runs into the watchdog
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    task automatic rises(input int n);
        repeat (n) do @(posedge sys_clk); while (rise !== 1'b1);
    endtask : rises

    task automatic wait_valid;
        while (data_valid !== 1'b1) @(posedge sys_clk);
    endtask : wait_valid

    // ----------------------------------------------------------
    // reference pipe: saturate, then msb inverted for twos
    // ----------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rise) begin
            r = $urandom;
            core_code <= 12'(r >> 4);
            core_over <= (r % 8) == 0;
            core_under <= (r % 8) == 1;
        end
        if (!(cmp && data_valid)) begin
            q.delete();
            pv = 1'b0;
        end else if (rise) q.push_back({core_over | core_under,
            (core_over ? 12'hfff : core_under ? 12'h000 : core_code)
            ^ {mode_level[1], 11'h000}});
        else if (fall && q.size() == LAT + 2) begin
            // the far side took the previous word at the last rise
            if (pv) chk(cap, prev);
            prev = q.pop_front();
            pv = 1'b1;
            chk({overflow_flag, sample_word}, prev);
        end
    end

    initial begin
        #3000000;
        num_errors++;
        finish_test();
    end

    initial begin
        void'($urandom(74));
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        chk(avs_waitrequest, 1'b1);
        for (int m = 0; m < 4; m++) begin
            mode_level <= 2'(m);
            repeat (80) @(posedge sys_clk);
            wait_valid();
            bus(1'b0, adcc_pkg::OFS_STATUS, 32'h0);
            chk(rd[4:0], {3'b001, 1'(m == 1 || m == 2), 1'(m >= 2)});
            cmp <= 1'b1;
            rises(40);
            cmp <= 1'b0;
            $display("mode test %0d done", m);
        end
        bus(1'b1, adcc_pkg::OFS_IRQ_EN, 32'h2);
        mode_level <= 2'h1;
        run <= 1'b0;
        repeat (40) @(posedge sys_clk);
        run <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(irq, 1'b1);
        bus(1'b1, adcc_pkg::OFS_IRQ_CLR, 32'h2);
        bus(1'b0, adcc_pkg::OFS_IRQ_STAT, 32'h0);
        chk(rd & 32'h2, 32'h0);
        bus(1'b1, adcc_pkg::OFS_IRQ_EN, 32'h0);
        run <= 1'b0;
        repeat (40) @(posedge sys_clk);
        run <= 1'b1;
        bus(1'b0, adcc_pkg::OFS_IRQ_STAT, 32'h0);
        chk(rd & 32'h2, 32'h2);
        chk(irq, 1'b0);
        bus(1'b0, 5'h1c, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, adcc_pkg::OFS_CTRL, 32'h5);
        bus(1'b0, adcc_pkg::OFS_STATUS, 32'h0);
        chk(rd[1:0], 2'b11);
        bus(1'b1, adcc_pkg::OFS_CTRL, 32'h0);
        $display("irq test done");
        oc_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({sample_word_oe, overflow_flag_oe}, 2'b00);
        oc_n <= 1'b0;
        pds <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({sample_word_oe, overflow_flag_oe, data_valid}, 3'b000);
        bus(1'b0, adcc_pkg::OFS_STATUS, 32'h0);
        chk(rd[4:2], 3'b010);
        pds <= 1'b0;
        rises(95);
        chk(data_valid, 1'b0);
        rises(10);
        chk(data_valid, 1'b1);
        $display("nap test done");
        oc_n <= 1'b1;
        pds <= 1'b1;
        repeat (3) @(posedge sys_clk);
        bus(1'b0, adcc_pkg::OFS_STATUS, 32'h0);
        chk({rd[4:2], sample_word_oe, data_valid}, 5'b10000);
        pds <= 1'b0;
        oc_n <= 1'b0;
        rises(105);
        chk(data_valid, 1'b0);
        wait_valid();
        chk(sample_word_oe, 1'b1);
        cmp <= 1'b1;
        rises(20);
        $display("sleep test done");
        finish_test();
    end
endmodule : adcc_ctrl_tb
